/* hdl/gptu_top.sv */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - Five 16-bit timers: three in module a, two plus capture register in b.
// - Each module a timer selects timer, gated, counter or incremental mode.
// - Timer mode counts the clock divided by 8 to 1024 (module b 4 to 512), select doubles it.
// - Counter mode advances on edges of the timer's own input pin.
// - Gated mode counts prescaled ticks only while the pin shows gate level.
// - Software picks up or down; a direction pin may flip it.
// - Incremental mode decodes quadrature A and B into count and direction.
// - Core a toggle latch inverts on each wrap and can drive a pin.
// - Core a toggle latch may clock either module a auxiliary timer.
// - An auxiliary timer used for capture or reload does not count.
// - Capture: aux pin edge copies core a value into the auxiliary timer.
// - Reload: core a loads from aux on pin edge or chosen latch edge.
// - Auxiliaries reloading on opposite latch edges give a free waveform.
// - Auxiliary timers chain with the core timer of their own module.
// - Module b timers count prescaled clock or external signals.
// - Core b toggle latch changes on every wrap, supporting chaining.
// - Core b latch clocks aux b or drives an output pin.
// - Core b wraps clock capture/compare timers and reload from capture.
// - Capture pin edge copies aux b into capture register, optional clear.
// - Capture may instead trigger on core a input or direction pin edges.

module gptu_top #(
  parameter int unsigned TW = gptu_pkg::TMR_W
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_b,
  input  wire logic [gptu_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [TW-1:0]               i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  input  wire logic [gptu_pkg::TMR_N-1:0]  i_timer_count_gate_pin,
  input  wire logic [gptu_pkg::TMR_N-1:0]  i_timer_direction_pin,
  input  wire logic                        i_capture_input_pin,
  output logic      [TW-1:0]               o_rdata,
  output logic                             o_core_a_toggle_pin,
  output logic                             o_core_b_toggle_pin,
  output logic                             o_capcom_tick
);

  localparam int unsigned N = gptu_pkg::TMR_N;
  localparam int unsigned CA = gptu_pkg::T_CORE_A;
  localparam int unsigned CB = gptu_pkg::T_CORE_B;
  localparam int unsigned XB = gptu_pkg::T_AUX_B;

  gptu_pkg::gptu_ctl_s          ctl [N];
  logic [TW-1:0]                cnt [N];
  logic [TW-1:0]                ldv [N];
  logic [N-1:0]                 tick;
  logic [N-1:0]                 dn;
  logic [N-1:0]                 ld;
  logic [N-1:0]                 wrap;
  logic [N-1:0]                 pe;
  logic [N-1:0]                 sw_cnt;
  logic [N-1:0]                 cap_a;
  logic [N-1:0]                 rl_a;
  logic [N-1:0]                 pin_q;
  logic [N-1:0]                 dir_q;
  logic                         cap_q;
  logic [gptu_pkg::DIV_W-1:0]   div;
  logic                         otl_a;
  logic                         otl_b;
  logic [TW-1:0]                capreg;
  logic [5:0]                   flags;
  logic                         cap_b;
  logic                         any_a;
  logic                         any_d;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Prescaler tap: low bits of the free divider all ones
  function automatic logic presc_hit(
    input logic [gptu_pkg::DIV_W-1:0] d,
    input logic [2:0]                 sel,
    input logic [3:0]                 base
  );
    logic [3:0]                 n;
    logic [gptu_pkg::DIV_W-1:0] m;
    n = {1'b0, sel} + base;
    m = gptu_pkg::DIV_W'((11'h001 << n) - 11'h001);
    return (d & m) == m;
  endfunction

  // Write strobe to one register index
  function automatic logic wr_hit(
    input logic                        wr,
    input logic [gptu_pkg::ADDR_W-1:0] a,
    input logic [gptu_pkg::ADDR_W-1:0] idx
  );
    return wr && (a == idx);
  endfunction

  // ----------------------------------------------------------------
  // Prescaler and pin history
  // ----------------------------------------------------------------

  // One free divider serves every tap, so all timers stay phase aligned
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      div <= '0;
    else
      div <= gptu_pkg::DIV_W'(div + 1'b1);
  end

  // Previous pin levels for edge detection
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_q <= '0;
      dir_q <= '0;
      cap_q <= 1'b0;
    end
    else
    begin
      pin_q <= i_timer_count_gate_pin;
      dir_q <= i_timer_direction_pin;
      cap_q <= i_capture_input_pin;
    end
  end

  assign any_a = i_timer_count_gate_pin[CA] ^ pin_q[CA];
  assign any_d = i_timer_direction_pin[CA] ^ dir_q[CA];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // Everything stopped and zero after reset
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int k = 0; k < N; k++)
        ctl[k] <= gptu_pkg::CTL_RST;
    end
    else
    begin
      for (int k = 0; k < N; k++)
        if (wr_hit(i_wr, i_addr, gptu_pkg::REG_CTL0 + 4'(k)))
          ctl[k] <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Timer slices
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_tmr
      localparam bit MOD_A = (i < CB);
      localparam bit IS_AUX = (i != CA) && (i != CB);
      logic pt;
      logic pin;
      logic gate_ok;
      logic src;
      logic chain_ev;
      logic qev;
      logic qdn;
      logic halt;

      assign pin = i_timer_count_gate_pin[i];
      // Edge selected by polarity bit: 0 rising, 1 falling
      assign pe[i] = ctl[i].pol ? (pin_q[i] & ~pin)
                                : (pin & ~pin_q[i]);
      assign pt = presc_hit(div, ctl[i].sel, MOD_A
                  ? gptu_pkg::PRE_BASE_A
                  : gptu_pkg::PRE_BASE_B);
      assign gate_ok = (pin != ctl[i].pol);
      // Auxiliaries may count their core's toggle latch changes
      assign chain_ev = IS_AUX && ctl[i].chain &&
                        (MOD_A ? wrap[CA] : wrap[CB]);
      assign src = (IS_AUX && ctl[i].chain) ? chain_ev
                                            : pe[i];
      // Quadrature: any edge counts, direction from A versus old B
      assign qev = MOD_A && ((pin ^ pin_q[i]) |
                   (i_timer_direction_pin[i] ^ dir_q[i]));
      assign qdn = ~(pin ^ dir_q[i]) ^ ctl[i].down;
      assign halt = MOD_A && IS_AUX &&
                    (ctl[i].aux != gptu_pkg::AUX_NORMAL);

      // Count enable by mode
      assign tick[i] = ctl[i].run && !halt &&
        ((ctl[i].mode == gptu_pkg::MODE_TIMER)   ? pt :
         (ctl[i].mode == gptu_pkg::MODE_GATED)   ? pt && gate_ok :
         (ctl[i].mode == gptu_pkg::MODE_COUNTER) ? src :
         (MOD_A ? qev : src));

      assign dn[i] = (MOD_A && ctl[i].mode == gptu_pkg::MODE_INCR)
        ? qdn
        : ctl[i].down ^ (ctl[i].ext_dir &
                         i_timer_direction_pin[i]);

      assign sw_cnt[i] = wr_hit(i_wr, i_addr,
                                gptu_pkg::REG_CNT0 + 4'(i));

      // Capture and reload roles exist only for module a auxiliaries
      if (MOD_A && IS_AUX)
      begin : g_role
        logic hit;
        always_comb
        begin
          unique case (ctl[i].trig)
            2'h0:    hit = pe[i];
            2'h1:    hit = wrap[CA] && !otl_a; // latch rises
            2'h2:    hit = wrap[CA] && otl_a;  // latch falls
            default: hit = wrap[CA];
          endcase
        end
        assign cap_a[i] = (ctl[i].aux == gptu_pkg::AUX_CAPTURE) &&
                          pe[i];
        assign rl_a[i] = (ctl[i].aux == gptu_pkg::AUX_RELOAD) &&
                         hit;
      end
      else
      begin : g_norole
        assign cap_a[i] = 1'b0;
        assign rl_a[i] = 1'b0;
      end

      gptu_timer #(
        .TW (TW)
      ) u_tmr (
        .i_clk_sys  (i_clk_sys),
        .i_rst_b    (i_rst_b),
        .i_tick     (tick[i]),
        .i_down     (dn[i]),
        .i_load     (ld[i]),
        .i_load_val (ldv[i]),
        .o_count    (cnt[i]),
        .o_wrap     (wrap[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Capture trigger for the capture register
  // ----------------------------------------------------------------

  // 0 capture pin rise, 1 fall, 2 core a input edge, 3 either core pin
  always_comb
  begin
    unique case (ctl[XB].trig)
      2'h0:    cap_b = i_capture_input_pin & ~cap_q;
      2'h1:    cap_b = cap_q & ~i_capture_input_pin;
      2'h2:    cap_b = any_a;
      default: cap_b = any_a | any_d;
    endcase
  end

  // ----------------------------------------------------------------
  // Load selection; software writes take priority
  // ----------------------------------------------------------------
  always_comb
  begin
    ld = sw_cnt;
    for (int k = 0; k < N; k++)
      ldv[k] = i_wdata;
    if (!sw_cnt[CA])
    begin
      if (rl_a[gptu_pkg::T_AUX_AL])
      begin
        ld[CA] = 1'b1;
        ldv[CA] = cnt[gptu_pkg::T_AUX_AL];
      end
      else if (rl_a[gptu_pkg::T_AUX_AH])
      begin
        ld[CA] = 1'b1;
        ldv[CA] = cnt[gptu_pkg::T_AUX_AH];
      end
    end
    for (int k = 1; k < CB; k++)
      if (!sw_cnt[k] && cap_a[k])
      begin
        ld[k] = 1'b1;
        ldv[k] = cnt[CA];
      end
    if (!sw_cnt[CB] && ctl[CB].opt && wrap[CB])
    begin
      ld[CB] = 1'b1;
      ldv[CB] = capreg;
    end
    if (!sw_cnt[XB] && ctl[XB].opt && cap_b)
    begin
      ld[XB] = 1'b1;
      ldv[XB] = '0;
    end
  end

  // ----------------------------------------------------------------
  // Capture register, latches, flags
  // ----------------------------------------------------------------

  // Capture register; software write wins over a capture
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      capreg <= gptu_pkg::CNT_RST;
    else if (wr_hit(i_wr, i_addr, gptu_pkg::REG_CAPTURE_RELOAD_REG))
      capreg <= i_wdata;
    else if (cap_b)
      capreg <= cnt[XB];
  end

  // Toggle latches invert on every wrap
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      otl_a <= 1'b0;
      otl_b <= 1'b0;
    end
    else
    begin
      otl_a <= otl_a ^ wrap[CA];
      otl_b <= otl_b ^ wrap[CB];
    end
  end

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      flags <= '0;
    else if (wr_hit(i_wr, i_addr, gptu_pkg::REG_STAT))
      flags <= (flags & ~i_wdata[5:0]) | {cap_b, wrap};
    else
      flags <= flags | {cap_b, wrap};
  end

  // Outputs are registered, one cycle behind the latch (toggle pins) or the core b wrap (capcom tick)
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_core_a_toggle_pin <= 1'b0;
      o_core_b_toggle_pin <= 1'b0;
      o_capcom_tick <= 1'b0;
    end
    else
    begin
      o_core_a_toggle_pin <= ctl[CA].opt & otl_a;
      o_core_b_toggle_pin <= ctl[CB].opt & otl_b;
      o_capcom_tick <= wrap[CB];
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------

  // Data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rdata <= '0;
    else if (!i_rd)
      o_rdata <= '0;
    else if (i_addr < gptu_pkg::REG_CNT0)
      o_rdata <= ctl[3'(i_addr)];
    else if (i_addr < gptu_pkg::REG_CAPTURE_RELOAD_REG)
      o_rdata <= cnt[3'(i_addr - gptu_pkg::REG_CNT0)];
    else if (i_addr == gptu_pkg::REG_CAPTURE_RELOAD_REG)
      o_rdata <= capreg;
    else if (i_addr == gptu_pkg::REG_STAT)
    begin
      o_rdata <= TW'(flags);
      o_rdata[gptu_pkg::STAT_OTLA] <= otl_a;
      o_rdata[gptu_pkg::STAT_OTLB] <= otl_b;
    end
    else
      o_rdata <= '0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  a_latch_toggles_a:
    assert property (wrap[CA] |=> otl_a != $past(otl_a))
    else $error("core a latch did not toggle");

  a_aux_halted:
    assert property (ctl[1].aux != gptu_pkg::AUX_NORMAL |-> !tick[1])
    else $error("aux in capture role counted");

  a_capture_core:
    assert property (cap_a[1] && !sw_cnt[1] |=> cnt[1] == $past(cnt[CA]))
    else $error("capture value wrong");

  a_reload_core:
    assert property (rl_a[1] && !sw_cnt[CA] |=> cnt[CA] == $past(cnt[1]))
    else $error("core a reload wrong");

  a_capreg_grab:
    assert property (cap_b && !wr_hit(i_wr, i_addr, gptu_pkg::REG_CAPTURE_RELOAD_REG)
                     |=> capreg == $past(cnt[XB]))
    else $error("capture register value wrong");

  a_flag_sticky:
    assert property (wrap[CB] |=> flags[CB] ##1 (flags[CB] || ($past(i_wr) &&
                     $past(i_addr) == gptu_pkg::REG_STAT)))
    else $error("wrap flag lost");

  a_capcom_feed:
    assert property (o_capcom_tick == $past(wrap[CB]))
    else $error("capture/compare tick wrong");

  a_prescale_tap:
    assert property (tick[CA] && ctl[CA].mode == gptu_pkg::MODE_TIMER
                     |-> div[2:0] == 3'h7)
    else $error("core a tick off the divider tap");

  a_chain_b:
    assert property (ctl[XB].run && ctl[XB].chain &&
                     ctl[XB].mode == gptu_pkg::MODE_COUNTER && wrap[CB]
                     |-> tick[XB])
    else $error("aux b missed core b latch change");

  a_pin_follows:
    assert property (ctl[CA].opt && $stable(ctl[CA].opt)
                     |-> o_core_a_toggle_pin == $past(otl_a))
    else $error("toggle pin wrong");

  c_wrap_a:   cover property (wrap[CA]);
  c_reload_a: cover property (rl_a[1] ##[1:300] rl_a[2]);
  c_capture:  cover property (cap_b && ctl[XB].opt);
  c_quad:     cover property (tick[CA] &&
                              ctl[CA].mode == gptu_pkg::MODE_INCR);

endmodule

/* hdl/gptu_pkg.sv */
package gptu_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned TMR_N  = 5;
  localparam int unsigned TMR_W  = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DIV_W  = 10;

  // Timer slots: module a core, a low aux, a high aux, b core, b aux
  localparam int unsigned T_CORE_A = 0;
  localparam int unsigned T_AUX_AL = 1;
  localparam int unsigned T_AUX_AH = 2;
  localparam int unsigned T_CORE_B = 3;
  localparam int unsigned T_AUX_B  = 4;

  // ----------------------------------------------------------------
  // Register map (word index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTL0   = 4'h0;
  localparam logic [3:0] REG_CNT0   = 4'h5;
  localparam logic [3:0] REG_CAPTURE_RELOAD_REG = 4'hA;
  localparam logic [3:0] REG_STAT   = 4'hB;

  localparam logic [15:0] CTL_RST   = 16'h0000;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  // Status layout: bits 4..0 timer wrap flags
  localparam int unsigned STAT_CAP  = 5;
  localparam int unsigned STAT_OTLA = 8;
  localparam int unsigned STAT_OTLB = 9;

  // Prescaler exponents: module a 8..1024, module b 4..512
  localparam logic [3:0] PRE_BASE_A = 4'h3;
  localparam logic [3:0] PRE_BASE_B = 4'h2;

  typedef enum logic [1:0] {
    MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_INCR
  } gptu_mode_e;

  typedef enum logic [1:0] {
    AUX_NORMAL, AUX_CAPTURE, AUX_RELOAD, AUX_SPARE
  } gptu_aux_e;

  // One control word per timer
  typedef struct packed {
    logic       spare;   // 15
    logic       chain;   // 14 count toggle latch changes
    logic       opt;     // 13 pin enable / reload / clear
    logic [1:0] trig;    // 12:11 trigger select
    gptu_aux_e  aux;     // 10:9
    logic       pol;     // 8 edge or gate polarity
    logic       ext_dir; // 7
    logic       down;    // 6
    logic       run;     // 5
    gptu_mode_e mode;    // 4:3
    logic [2:0] sel;     // 2:0 prescaler select
  } gptu_ctl_s;

endpackage

/* hdl/gptu_timer.sv */
`timescale 1ns/1ps

module gptu_timer #(
  parameter int unsigned TW = gptu_pkg::TMR_W
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_b,
  input  wire logic          i_tick,
  input  wire logic          i_down,
  input  wire logic          i_load,
  input  wire logic [TW-1:0] i_load_val,
  output logic      [TW-1:0] o_count,
  output logic               o_wrap
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------

  // A load beats a count step so a reload replaces the wrapped value
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_count <= gptu_pkg::CNT_RST;
    else if (i_load)
      o_count <= i_load_val;
    else if (i_tick)
      o_count <= i_down ? TW'(o_count - 1'b1) : TW'(o_count + 1'b1);
  end

  // Wrap ignores the load, which would otherwise close a loop
  assign o_wrap = i_tick && (i_down ? (o_count == '0) : (&o_count));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  a_count_step:
    assert property (i_tick && !i_load |=>
      o_count == ($past(i_down) ? TW'($past(o_count) - 1'b1)
                                : TW'($past(o_count) + 1'b1)))
    else $error("timer step wrong");

endmodule

/* dv/gptu_pins.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// External pin model: encoders, gates and event sources
// ----------------------------------------------------------------
module gptu_pins (
  input  wire logic       i_clk_sys,
  output logic      [4:0] o_gate,
  output logic      [4:0] o_dir,
  output logic            o_cap
);
  logic [1:0] quad_tbl [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  logic [1:0] ph = 2'b00;

  initial
  begin
    o_gate = 5'h00;
    o_dir  = 5'h00;
    o_cap  = 1'b0;
  end

  // Static levels for gate and direction inputs of timer 0
  task automatic lvl(input logic g, input logic d);
    @(posedge i_clk_sys);
    o_gate[0] <= g;
    o_dir[0]  <= d;
  endtask

  // Each level held two cycles so the one-cycle sampler sees it
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      @(posedge i_clk_sys);
      o_gate[idx] <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      o_gate[idx] <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
    end
  endtask

  task automatic cap_pulse();
    @(posedge i_clk_sys);
    o_cap <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    o_cap <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask

  // Gray steps on A and B; one line changes per step
  task automatic quad(input int n, input logic fwd);
    repeat (4 * n)
    begin
      ph = fwd ? ph + 2'd1 : ph - 2'd1;
      @(posedge i_clk_sys);
      o_gate[0] <= quad_tbl[ph][1];
      o_dir[0]  <= quad_tbl[ph][0];
      repeat (2) @(posedge i_clk_sys);
    end
  endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        i_clk_sys;
  logic        i_rst_b;
  logic [3:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  logic        o_core_a_toggle_pin;
  logic        o_core_b_toggle_pin;
  logic        o_capcom_tick;
  logic [4:0]  gate;
  logic [4:0]  dir;
  logic        cap;
  logic [15:0] a, b, s, r;
  logic [31:0] seed = 32'h9529;
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_tick = 0;
  int          cyc = 0;
  int          t0;
  // Model of timer 0 steps per row: control word and direction sign
  logic [15:0] rows [7] = '{16'h0020, 16'h0021, 16'h0022, 16'h0060,
                            16'h00A0, 16'h0028, 16'h0028};
  int          sgn [7] = '{1, 1, 1, -1, -1, 0, 1};

  gptu_top uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_timer_count_gate_pin(gate), .i_timer_direction_pin(dir),
    .i_capture_input_pin(cap), .o_rdata(o_rdata),
    .o_core_a_toggle_pin(o_core_a_toggle_pin),
    .o_core_b_toggle_pin(o_core_b_toggle_pin),
    .o_capcom_tick(o_capcom_tick));
  gptu_pins pins (.i_clk_sys(i_clk_sys), .o_gate(gate), .o_dir(dir),
    .o_cap(cap));

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // Whole run is well under a thousand cycles; the ceiling leaves margin
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (o_capcom_tick === 1'b1)
      n_tick <= n_tick + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= ad;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad, output logic [15:0] v);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= ad;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_rst_b = 1'b0;
    i_addr  = 4'h0;
    i_wdata = 16'h0000;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    repeat (10) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    // Reset contents, including one unmapped index
    for (int i = 0; i < 13; i++)
    begin
      rd(i[3:0], a);
      chk("reset reg", a, 16'h0000);
    end
    chk("pin a", {15'h0, o_core_a_toggle_pin}, 16'h0000);
    // Prescale, direction and gate rows; reads spaced whole periods
    for (int i = 0; i < 7; i++)
    begin
      pins.lvl(i == 6, i == 4);
      wr(4'h0, rows[i]);
      rd(4'h5, a);
      repeat ((4 << (rows[i][2:0] + 3)) - 2) @(posedge i_clk_sys);
      rd(4'h5, b);
      chk("cnt0 step", b - a, 16'(sgn[i] * 4));
    end
    // Wrap from all ones in counter mode
    pins.lvl(1'b0, 1'b0);
    wr(4'hB, 16'hFFFF);
    rd(4'hB, s);
    wr(4'h0, 16'h2030);
    wr(4'h5, 16'hFFFF);
    pins.pulse(0, 1);
    rd(4'h5, a);
    chk("cnt0 wrap", a, 16'h0000);
    rd(4'hB, b);
    chk("wrap flag", {15'h0, b[0]}, 16'h0001);
    chk("latch a", {15'h0, b[8]}, {15'h0, ~s[8]});
    chk("pin a", {15'h0, o_core_a_toggle_pin}, {15'h0, b[8]});
    wr(4'hB, 16'h0001);
    rd(4'hB, b);
    chk("flag clear", {15'h0, b[0]}, 16'h0000);
    seed = lfsr(seed);
    r = seed[15:0];
    wr(4'h5, r);
    pins.pulse(0, 3);
    rd(4'h5, a);
    chk("cnt0 events", a, r + 16'h0003);
    // Capture of core a into aux low; aux must not count meanwhile
    wr(4'h0, 16'h0030);
    wr(4'h1, 16'h0220);
    wr(4'h6, 16'h0000);
    pins.pulse(1, 1);
    rd(4'h6, a);
    chk("capture", a, r + 16'h0003);
    repeat (64) @(posedge i_clk_sys);
    rd(4'h6, a);
    chk("aux stopped", a, r + 16'h0003);
    // Quadrature: two turns forward, one back
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0038);
    wr(4'h5, 16'h0064);
    pins.quad(2, 1'b1);
    pins.quad(1, 1'b0);
    rd(4'h5, a);
    chk("quad pos", a, 16'h0068);
    // Reload core a from aux low on its pin; aux high counts latch changes
    seed = lfsr(seed);
    r = seed[15:0];
    wr(4'h0, 16'h0030);
    wr(4'h1, 16'h0420);
    wr(4'h6, r);
    wr(4'h2, 16'h4030);
    wr(4'h7, 16'h0000);
    pins.pulse(1, 1);
    rd(4'h5, a);
    chk("reload a", a, r);
    wr(4'h5, 16'hFFFF);
    pins.pulse(0, 1);
    rd(4'h7, a);
    chk("chain a", a, 16'h0001);
    // Capture register takes aux b, then aux b clears
    seed = lfsr(seed);
    r = seed[15:0];
    wr(4'h4, 16'h2030);
    wr(4'h9, r);
    pins.cap_pulse();
    rd(4'hA, a);
    chk("capreg", a, r);
    rd(4'h9, a);
    chk("aux b clear", a, 16'h0000);
    rd(4'hB, s);
    chk("cap flag", {15'h0, s[5]}, 16'h0001);
    // Core b wrap: latch, pin and capcom tick
    wr(4'h3, 16'h2030);
    wr(4'h4, 16'h6030);
    wr(4'h8, 16'hFFFF);
    t0 = n_tick;
    pins.pulse(3, 1);
    rd(4'hB, b);
    chk("latch b", {15'h0, b[9]}, {15'h0, ~s[9]});
    chk("pin b", {15'h0, o_core_b_toggle_pin}, {15'h0, b[9]});
    chk("capcom tick", 16'(n_tick - t0), 16'h0001);
    rd(4'h8, a);
    chk("core b reload", a, r);
    rd(4'h9, a);
    chk("chain b", a, 16'h0001);
    give_verdict();
  end
endmodule
